// ### sfcm_pkg.sv
// sfcm_pkg: constants and types for the safety fault category manager
// assumes: one clock, synchronous active-high reset, no software registers
// How it works
// - sort each fault into three categories
// - recoverable fault forces output off, field interrupted
// - cause gone, output on again without restart
// - invalid case-select signal is recoverable
// - missing or bad network data is recoverable
// - front window contamination fault is recoverable
// - supply voltage too low is recoverable
// - excess ambient light is recoverable
// - configuration fault holds until config checked
// - device fault latches interlock, output off
// - interlock releases only by restart
// - every fault onset logs one history record
// - contamination warning only signalled, output unchanged
// - contamination warning and fault reported over network
package sfcm_pkg;
    // ****************************************
    // fault source indices
    // ****************************************
    localparam int SRC_CASE    = 0;
    localparam int SRC_NETDATA = 1;
    localparam int SRC_CONTAM  = 2;
    localparam int SRC_VOLTAGE = 3;
    localparam int SRC_AMBIENT = 4;
    localparam int SRC_CONFIG  = 5;
    localparam int SRC_DEVICE  = 6;
    localparam int NUM_SRC     = 7;

    // ****************************************
    // history layout
    // ****************************************
    localparam int HIST_DEPTH  = 16;
    localparam int HIST_AW     = 4;
    localparam int CODE_W      = 3;
    localparam int STAMP_W     = 32;
    localparam int REC_W       = CODE_W + 2 + STAMP_W;

    localparam logic [1:0] CAT_RECOV  = 2'h0;
    localparam logic [1:0] CAT_CONFIG = 2'h1;
    localparam logic [1:0] CAT_DEVICE = 2'h2;

    typedef enum logic [1:0] {
        SFCM_RUN,
        SFCM_RECOV,
        SFCM_CONFIG,
        SFCM_LOCKED
    } sfcm_state_t;
endpackage

// ### sfcm_history.sv
// sfcm_history: ring buffer of fault records
// assumes: at most one write per cycle, caller serialises onsets
`timescale 1ns/100ps
`default_nettype none
module sfcm_history (
    input  wire logic                       sys_clk,
    input  wire logic                       reset,
    input  wire logic                       wrEn,
    input  wire logic [sfcm_pkg::REC_W-1:0] wrRec,
    input  wire logic [sfcm_pkg::HIST_AW-1:0] rdIdx,
    output logic      [sfcm_pkg::REC_W-1:0] rdRec,
    output logic      [sfcm_pkg::HIST_AW-1:0] wrPtr,
    output logic                            wrapped
);
    logic [sfcm_pkg::REC_W-1:0]   mem [sfcm_pkg::HIST_DEPTH];
    logic [sfcm_pkg::HIST_AW-1:0] ptr_q;
    logic [sfcm_pkg::HIST_AW-1:0] ptr_d;
    logic                         wrap_q;
    logic                         wrap_d;
    logic [sfcm_pkg::REC_W-1:0]   rd_q;

    // ****************************************
    // pointer
    // ****************************************
    always_comb begin
        ptr_d  = ptr_q;
        wrap_d = wrap_q;
        if (wrEn) begin
            ptr_d = ptr_q + 1'b1;
            // oldest record overwritten once full
            if (ptr_q == sfcm_pkg::HIST_AW'(sfcm_pkg::HIST_DEPTH - 1)) begin
                wrap_d = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ptr_q  <= '0;
            wrap_q <= 1'b0;
            rd_q   <= '0;
        end else begin
            ptr_q  <= ptr_d;
            wrap_q <= wrap_d;
            rd_q   <= mem[rdIdx];
        end
    end

    // no reset on storage; read data masked by reset of rd_q only
    always_ff @(posedge sys_clk) begin
        if (wrEn) begin
            mem[ptr_q] <= wrRec;
        end
    end

    assign rdRec   = rd_q;
    assign wrPtr   = ptr_q;
    assign wrapped = wrap_q;
endmodule
`default_nettype wire

// ### sfcm_manager.sv
// sfcm_manager: fault supervisor driving safety output and field status
// assumes: fault inputs are pins from other domains; restart is a reset pulse
`timescale 1ns/100ps
`default_nettype none
module sfcm_manager (
    input  wire logic                         sys_clk,
    input  wire logic                         reset,
    input  wire logic                         caseSelInvalid,
    input  wire logic                         netDataMissing,
    input  wire logic                         netDataBad,
    input  wire logic                         nmtOperational,
    input  wire logic                         contamWarning,
    input  wire logic                         contamFault,
    input  wire logic                         supplyLow,
    input  wire logic                         ambientHigh,
    input  wire logic                         configFault,
    input  wire logic                         configVerified,
    input  wire logic                         deviceFault,
    input  wire logic [sfcm_pkg::HIST_AW-1:0] histRdIdx,
    output logic                              safetyOutOn,
    output logic                              fieldFree,
    output logic                              recovActive,
    output logic                              configActive,
    output logic                              interlocked,
    output logic                              netContamWarn,
    output logic                              netContamFault,
    output logic                              histWrite,
    output logic      [sfcm_pkg::REC_W-1:0]   histRdRec,
    output logic      [sfcm_pkg::HIST_AW-1:0] histCount,
    output logic                              histWrapped
);
    localparam int NIN = 11;

    // ****************************************
    // input synchronisers (three stages)
    // ****************************************
    logic [NIN-1:0] rawIn;
    logic [NIN-1:0] s1_q;
    logic [NIN-1:0] s2_q;
    logic [NIN-1:0] s3_q;
    logic [NIN-1:0] flt_q;
    logic [NIN-1:0] flt_d;

    assign rawIn = {configVerified, contamWarning, nmtOperational, netDataBad,
                    deviceFault, configFault, ambientHigh, supplyLow,
                    contamFault, netDataMissing, caseSelInvalid};

    genvar gi;
    generate
        for (gi = 0; gi < NIN; gi++) begin : g_filt
            // a change counts once stage two and three agree
            always_comb begin
                flt_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : flt_q[gi];
            end
        end
    endgenerate

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            flt_q <= '0;
        end else begin
            s1_q  <= rawIn;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            flt_q <= flt_d;
        end
    end

    logic fCase, fNetMiss, fContam, fSupply, fAmbient, fConfig, fDevice;
    logic fNetBad, fNmtOp, fContWarn, fCfgOk;
    assign {fCfgOk, fContWarn, fNmtOp, fNetBad, fDevice, fConfig, fAmbient,
            fSupply, fContam, fNetMiss, fCase} = flt_q;

    // ****************************************
    // network data fault hold
    // ****************************************
    // stays set until master restores operational; set wins over clear
    logic netHold_q;
    logic netHold_d;
    always_comb begin
        netHold_d = netHold_q;
        if (fNmtOp && !fNetMiss && !fNetBad) begin
            netHold_d = 1'b0;
        end
        if (fNetMiss || fNetBad) begin
            netHold_d = 1'b1;
        end
    end

    // ****************************************
    // categories and latches
    // ****************************************
    logic [sfcm_pkg::NUM_SRC-1:0] src;
    logic                         recovAny;
    logic cfgHold_q, cfgHold_d, lock_q, lock_d;

    always_comb begin
        src = '0;
        src[sfcm_pkg::SRC_CASE]    = fCase;
        src[sfcm_pkg::SRC_NETDATA] = netHold_q;
        src[sfcm_pkg::SRC_CONTAM]  = fContam;
        src[sfcm_pkg::SRC_VOLTAGE] = fSupply;
        src[sfcm_pkg::SRC_AMBIENT] = fAmbient;
        src[sfcm_pkg::SRC_CONFIG]  = fConfig;
        src[sfcm_pkg::SRC_DEVICE]  = fDevice;
        recovAny = |src[sfcm_pkg::SRC_AMBIENT:sfcm_pkg::SRC_CASE];
        cfgHold_d = cfgHold_q;
        if (fCfgOk && !fConfig) begin
            cfgHold_d = 1'b0;
        end
        if (fConfig) begin
            cfgHold_d = 1'b1;
        end
        // only reset (restart) clears the interlock
        lock_d = lock_q | fDevice;
    end

    // ****************************************
    // category state
    // ****************************************
    // no separate state register: the decoded category flags are the registered state
    sfcm_pkg::sfcm_state_t st_d;
    always_comb begin
        case (1'b1)
            lock_d:    st_d = sfcm_pkg::SFCM_LOCKED;
            cfgHold_d: st_d = sfcm_pkg::SFCM_CONFIG;
            recovAny:  st_d = sfcm_pkg::SFCM_RECOV;
            default:   st_d = sfcm_pkg::SFCM_RUN;
        endcase
    end

    logic outOn_d;
    always_comb begin
        case (st_d)
            // contamination warning deliberately ignored here
            sfcm_pkg::SFCM_RUN: outOn_d = !fDevice && !fConfig;
            default:            outOn_d = 1'b0;
        endcase
    end

    // ****************************************
    // history logging of fault onsets
    // ****************************************
    // simultaneous onsets queue in a pending mask, one record per cycle
    logic [sfcm_pkg::NUM_SRC-1:0] prev_q, pend_q, pend_d;
    logic [sfcm_pkg::NUM_SRC-1:0] pendAll;
    logic                         wr_d;
    logic [sfcm_pkg::REC_W-1:0]   rec_d;
    logic [sfcm_pkg::STAMP_W-1:0] stamp_q;

    function automatic logic [1:0] catOf(input logic [sfcm_pkg::CODE_W-1:0] code);
        if (code == sfcm_pkg::CODE_W'(sfcm_pkg::SRC_DEVICE)) begin
            catOf = sfcm_pkg::CAT_DEVICE;
        end else if (code == sfcm_pkg::CODE_W'(sfcm_pkg::SRC_CONFIG)) begin
            catOf = sfcm_pkg::CAT_CONFIG;
        end else begin
            catOf = sfcm_pkg::CAT_RECOV;
        end
    endfunction

    always_comb begin
        logic [sfcm_pkg::CODE_W-1:0] code;
        code    = '0;
        pendAll = pend_q | (src & ~prev_q);
        pend_d  = pendAll;
        wr_d    = 1'b0;
        for (int i = sfcm_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (pendAll[i]) begin
                code = sfcm_pkg::CODE_W'(i);
            end
        end
        if (|pendAll) begin
            wr_d = 1'b1;
            pend_d[code] = 1'b0;
        end
        rec_d = {code, catOf(code), stamp_q};
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            netHold_q      <= 1'b0;
            cfgHold_q      <= 1'b0;
            lock_q         <= 1'b0;
            recovActive    <= 1'b0;
            configActive   <= 1'b0;
            interlocked    <= 1'b0;
            safetyOutOn    <= 1'b0;
            fieldFree      <= 1'b0;
            netContamWarn  <= 1'b0;
            netContamFault <= 1'b0;
            prev_q         <= '0;
            pend_q         <= '0;
            stamp_q        <= '0;
            histWrite      <= 1'b0;
        end else begin
            netHold_q      <= netHold_d;
            cfgHold_q      <= cfgHold_d;
            lock_q         <= lock_d;
            recovActive    <= (st_d == sfcm_pkg::SFCM_RECOV);
            configActive   <= (st_d == sfcm_pkg::SFCM_CONFIG);
            interlocked    <= (st_d == sfcm_pkg::SFCM_LOCKED);
            safetyOutOn    <= outOn_d;
            fieldFree      <= outOn_d;
            netContamWarn  <= fContWarn;
            netContamFault <= fContam;
            prev_q         <= src;
            pend_q         <= pend_d;
            stamp_q        <= stamp_q + 1'b1;
            histWrite      <= wr_d;
        end
    end

    logic [sfcm_pkg::REC_W-1:0] recOut_q;
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            recOut_q <= '0;
        end else begin
            recOut_q <= rec_d;
        end
    end

    sfcm_history u_hist (
        .sys_clk (sys_clk),
        .reset   (reset),
        .wrEn    (histWrite),
        .wrRec   (recOut_q),
        .rdIdx   (histRdIdx),
        .rdRec   (histRdRec),
        .wrPtr   (histCount),
        .wrapped (histWrapped)
    );
endmodule
`default_nettype wire

// ### sfcm_manager_monitor.sv
// sfcm_manager_monitor: port assertions for the fault manager
// assumes: bound onto sfcm_manager, one clock, sync reset
`timescale 1ns/100ps
`default_nettype none
module sfcm_manager_monitor (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic contamFault,
    input wire logic deviceFault,
    input wire logic safetyOutOn,
    input wire logic fieldFree,
    input wire logic recovActive,
    input wire logic configActive,
    input wire logic interlocked,
    input wire logic netContamFault
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    // ****
    // properties
    // ****
    property p_field_tracks; fieldFree == safetyOutOn; endproperty
    a_field_tracks: assert property (p_field_tracks)
        else $error("field status differs from output");
    property p_recov_off; recovActive |-> !safetyOutOn; endproperty
    a_recov_off: assert property (p_recov_off)
        else $error("output on during recoverable fault");
    property p_config_off; configActive |-> !safetyOutOn && !fieldFree; endproperty
    a_config_off: assert property (p_config_off)
        else $error("output on during config fault");
    property p_lock_off; interlocked |-> !safetyOutOn; endproperty
    a_lock_off: assert property (p_lock_off)
        else $error("output on while interlocked");
    property p_lock_hold; interlocked |=> interlocked; endproperty
    a_lock_hold: assert property (p_lock_hold)
        else $error("interlock released without restart");
    property p_on_clean; safetyOutOn |-> !(recovActive || configActive || interlocked); endproperty
    a_on_clean: assert property (p_on_clean)
        else $error("output on with a category active");
    property p_dev_lock; deviceFault [*8] |-> interlocked && !recovActive; endproperty
    a_dev_lock: assert property (p_dev_lock)
        else $error("device fault not interlocked");
    property p_contam; contamFault [*8] |-> netContamFault && !safetyOutOn; endproperty
    a_contam: assert property (p_contam)
        else $error("contamination fault not handled");
endmodule
bind sfcm_manager sfcm_manager_monitor sfcm_manager_monitor_inst (
    .sys_clk(sys_clk), .reset(reset), .contamFault(contamFault),
    .deviceFault(deviceFault), .safetyOutOn(safetyOutOn), .fieldFree(fieldFree),
    .recovActive(recovActive), .configActive(configActive),
    .interlocked(interlocked), .netContamFault(netContamFault));
`default_nettype wire

// ### sfcm_net_master.sv
// sfcm_net_master: network master model, data faults and state restore
// assumes: bench picks fault kind and restore speed
`timescale 1ns/100ps
`default_nettype none
module sfcm_net_master (
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic [1:0] faultReq,
    input  wire logic       slowNmt,
    output logic            netDataMissing,
    output logic            netDataBad,
    output logic            nmtOperational
);
    logic [3:0] waitCnt_q;
    // master holds pre-operational while data is broken, then restores
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            netDataMissing <= 1'b0;
            netDataBad     <= 1'b0;
            nmtOperational <= 1'b0;
            waitCnt_q      <= 4'h3;
        end else if (faultReq != 2'h0) begin
            netDataMissing <= faultReq[0];
            netDataBad     <= faultReq[1];
            nmtOperational <= 1'b0;
            waitCnt_q      <= slowNmt ? 4'hF : 4'h2;
        end else begin
            netDataMissing <= 1'b0;
            netDataBad     <= 1'b0;
            if (waitCnt_q != 4'h0) begin
                waitCnt_q <= waitCnt_q - 4'h1;
            end else begin
                nmtOperational <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ### tb_top.sv
// tb_top: self-checking bench for the fault manager
// assumes: sfcm_manager with bound monitor, network master model
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb_top;
    logic sys_clk, reset, contamWarning, configFault, configVerified, deviceFault, slowNmt;
    logic netDataMissing, netDataBad, nmtOperational, safetyOutOn, fieldFree, recovActive;
    logic configActive, interlocked, netContamWarn, netContamFault, histWrite, histWrapped;
    logic [3:0] rp, histRdIdx, histCount, expCnt;
    logic [1:0] faultReq;
    logic [sfcm_pkg::REC_W-1:0] histRdRec;
    int err_total, total_checks, n;
    sfcm_net_master sfcm_net_master_inst (.sys_clk(sys_clk), .reset(reset),
        .faultReq(faultReq), .slowNmt(slowNmt), .netDataMissing(netDataMissing),
        .netDataBad(netDataBad), .nmtOperational(nmtOperational));
    sfcm_manager sfcm_manager_inst (.sys_clk(sys_clk), .reset(reset),
        .caseSelInvalid(rp[0]), .netDataMissing(netDataMissing), .netDataBad(netDataBad),
        .nmtOperational(nmtOperational), .contamWarning(contamWarning), .contamFault(rp[1]),
        .supplyLow(rp[2]), .ambientHigh(rp[3]), .configFault(configFault),
        .configVerified(configVerified), .deviceFault(deviceFault), .histRdIdx(histRdIdx),
        .safetyOutOn(safetyOutOn), .fieldFree(fieldFree), .recovActive(recovActive),
        .configActive(configActive), .interlocked(interlocked),
        .netContamWarn(netContamWarn), .netContamFault(netContamFault),
        .histWrite(histWrite), .histRdRec(histRdRec), .histCount(histCount),
        .histWrapped(histWrapped));
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    task tally_and_finish;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // bounded wait for the output level
    task wait_out(input logic e);
        n = 0;
        while (safetyOutOn !== e && n < 40) begin
            @(posedge sys_clk); #1; n++;
        end
        `CHK("safetyOutOn", e, safetyOutOn)
        if (safetyOutOn !== e) tally_and_finish();
    endtask
    task step(input int c);
        repeat (c) @(posedge sys_clk);
        #1;
    endtask
    // ****
    // scenarios
    // ****
    task t_recov;
        logic [2:0] code [4];
        code = '{3'h0, 3'h2, 3'h3, 3'h4};
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk); rp[i] <= 1'b1; histRdIdx <= expCnt;
            wait_out(1'b0);
            `CHK("fieldFree", 1'b0, fieldFree)
            `CHK("recovActive", 1'b1, recovActive)
            step(3); expCnt++;
            `CHK("histCount", expCnt, histCount)
            `CHK("histCode", {code[i], 2'h0}, histRdRec[36:32])
            @(posedge sys_clk); rp[i] <= 1'b0;
            wait_out(1'b1);
            `CHK("fieldFree", 1'b1, fieldFree)
        end
    endtask
    task t_net;
        for (int k = 1; k < 3; k++) begin
            @(posedge sys_clk); faultReq <= k[1:0]; slowNmt <= 1'b1;
            wait_out(1'b0);
            step(2); @(posedge sys_clk); faultReq <= 2'h0;
            step(9); expCnt++;
            `CHK("heldForNmt", 1'b0, safetyOutOn)
            wait_out(1'b1);
            `CHK("histCount", expCnt, histCount)
        end
    endtask
    task t_warn;
        @(posedge sys_clk); contamWarning <= 1'b1;
        step(10);
        `CHK("warnOut", 1'b1, safetyOutOn)
        `CHK("netContamWarn", 1'b1, netContamWarn)
        `CHK("histCount", expCnt, histCount)
        @(posedge sys_clk); contamWarning <= 1'b0;
        @(posedge sys_clk); rp[1] <= 1'b1;
        wait_out(1'b0);
        `CHK("netContamFault", 1'b1, netContamFault)
        @(posedge sys_clk); rp[1] <= 1'b0; expCnt++;
        wait_out(1'b1);
    endtask
    task t_config;
        @(posedge sys_clk); configFault <= 1'b1; histRdIdx <= expCnt;
        wait_out(1'b0);
        `CHK("configActive", 1'b1, configActive)
        @(posedge sys_clk); configFault <= 1'b0;
        step(12); expCnt++;
        `CHK("configHeld", 1'b0, safetyOutOn)
        `CHK("histCfgCode", {3'h5, 2'h1}, histRdRec[36:32])
        @(posedge sys_clk); configVerified <= 1'b1;
        wait_out(1'b1);
        `CHK("histCount", expCnt, histCount)
        @(posedge sys_clk); configVerified <= 1'b0;
    endtask
    // repeated ambient faults: one record each, history fills up to slot 13
    task t_wrap;
        int pulses;
        for (int j = 0; j < 6; j++) begin
            pulses = 0;
            @(posedge sys_clk); rp[3] <= 1'b1;
            repeat (10) begin
                @(posedge sys_clk); #1;
                if (histWrite === 1'b1) pulses++;
            end
            `CHK("histWritePulses", 1, pulses)
            `CHK("ambientOut", 1'b0, safetyOutOn)
            @(posedge sys_clk); rp[3] <= 1'b0; expCnt++;
            wait_out(1'b1);
        end
        `CHK("histCount", expCnt, histCount)
        `CHK("histWrapped", 1'b0, histWrapped)
    endtask
    task t_device;
        @(posedge sys_clk); rp[2] <= 1'b1; deviceFault <= 1'b1; histRdIdx <= 4'hF;
        wait_out(1'b0);
        step(4); expCnt += 4'h2;
        `CHK("interlocked", 1'b1, interlocked)
        `CHK("recovActive", 1'b0, recovActive)
        `CHK("histCount", expCnt, histCount)
        `CHK("histWrapped", 1'b1, histWrapped)
        `CHK("histDevCode", {3'h6, 2'h2}, histRdRec[36:32])
        @(posedge sys_clk); rp[2] <= 1'b0; deviceFault <= 1'b0;
        step(15);
        `CHK("lockHeld", 1'b1, interlocked)
        @(posedge sys_clk); reset <= 1'b1;
        step(2); reset <= 1'b0;
        wait_out(1'b1);
        `CHK("interlocked", 1'b0, interlocked)
        `CHK("histCountRst", 4'h0, histCount)
        `CHK("histWrappedRst", 1'b0, histWrapped)
    endtask
    initial begin
        reset = 1'b1;
        {rp, faultReq, histRdIdx, expCnt} = 14'h0000;
        {contamWarning, configFault, configVerified, deviceFault, slowNmt} = 5'h00;
        err_total = 0;
        total_checks = 0;
        step(12); reset <= 1'b0;
        step(1);
        `CHK("histCount", 4'h0, histCount)
        wait_out(1'b1);
        t_recov();
        t_net();
        t_warn();
        t_config();
        t_wrap();
        t_device();
        tally_and_finish();
    end
endmodule
`default_nettype wire
